// [rtl/ssb_pkg.sv]
// shared constants and types of the state sequencer
package ssb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int OUT_W = 8;
    localparam int WORDS = 256;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 5;
    localparam int COND_COUNT = 3;
    localparam int SEL_W = 2;
    localparam logic [7:0] BOOT_ADDR = 8'h00;
    localparam logic [7:0] MWB_BASE = 8'hc0;
    localparam logic [7:0] MWB_MASK = 8'hc0;
    localparam logic [2:0] RESET_LONG_EDGES = 3'h3;
    localparam logic [1:0] RELEASE_HOLD_EDGES = 2'h2;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    typedef enum logic [3:0] {
        SSB_CONTINUE = 4'h0,
        SSB_JUMP = 4'h1,
        SSB_CALL = 4'h2,
        SSB_RETURN = 4'h3,
        SSB_LOAD_COUNT = 4'h4,
        SSB_LOOP_COUNT = 4'h5,
        SSB_DEC_COUNT = 4'h6,
        SSB_SAVE_LOAD_COUNT = 4'h7,
        SSB_POP_COUNT = 4'h8,
        SSB_PUSH = 4'h9,
        SSB_PUSH_INPUTS = 4'ha,
        SSB_PUSH_MASKED = 4'hb,
        SSB_POP_XOR_COUNT = 4'hc
    } ssb_op_e;

    // one program word: flag, opcode, next-address field, data field, outputs
    typedef struct packed {
        logic return_point_clause;
        ssb_op_e op;
        logic [ADDR_W-1:0] primary_target;
        logic [DATA_W-1:0] data_field;
        logic [OUT_W-1:0] outputs;
    } ssb_word_s;

    localparam ssb_word_s WORD_RESET = '0;

    // one branch condition: inputs masked then compared
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] match;
    } ssb_cond_s;
endpackage

// [rtl/ssb_branch_select.sv]
// four-way branch select from programmable input conditions
`timescale 1ns/1ps
`default_nettype none
module ssb_branch_select (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // condition programming
    input wire logic cond_we_in,
    input wire logic [1:0] cond_idx_in,
    input wire ssb_pkg::ssb_cond_s cond_in,
    input wire logic erase_in,
    // inputs and choice
    input wire logic [7:0] data_in,
    output logic [ssb_pkg::SEL_W-1:0] sel_out
);
    ssb_pkg::ssb_cond_s cond_reg [ssb_pkg::COND_COUNT];
    logic [ssb_pkg::COND_COUNT-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < ssb_pkg::COND_COUNT; i++)
        begin : g_cond
            assign hit[i] = ((data_in & cond_reg[i].mask) == cond_reg[i].match);
            always_ff @(posedge clk_in)
            begin
                if (reset_in || erase_in)
                    cond_reg[i] <= '0;
                else if (cond_we_in && cond_idx_in == 2'(i))
                    cond_reg[i] <= cond_in;
            end
        end
    endgenerate

    // first true condition wins, otherwise the last word
    assign sel_out = hit[0] ? 2'h0 : hit[1] ? 2'h1 : hit[2] ? 2'h2 : 2'h3;
endmodule
`default_nettype wire

// [rtl/ssb_sequencer.sv]
// next-state sequencer with stack, loop counter and multi-way branch
// Operation
// RULE_01: long reset holds boot word three edges; the code stalls on the boot word for two edges after release
// RULE_02: targets and constants are eight-bit values
// RULE_03: continue takes next sequential word
// RULE_04: jump takes target from current word
// RULE_05: call pushes return point, goes primary
// RULE_06: return takes stack top and pops
// RULE_07: multi-way block picks word from inputs
// RULE_08: security bit blocks readout until erase; the code also clears it on reset_in
// RULE_09: outside logic synchronises general inputs
// RULE_10: restart pin sampled on clock edge
// RULE_11: counter holds on branch instructions
// RULE_12: primary in next field, secondary in data
// RULE_13: selected word registered every rising edge; the code holds it on the two stall edges after a long restart
`timescale 1ns/1ps
`default_nettype none
module ssb_sequencer (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic restart_pin_low_in,
    // general inputs, synchronous to clk_in
    input wire logic [7:0] data_in,
    // programming port
    input wire logic prog_we_in,
    input wire logic [7:0] prog_addr_in,
    input wire ssb_pkg::ssb_word_s prog_word_in,
    input wire logic cond_we_in,
    input wire logic [1:0] cond_idx_in,
    input wire ssb_pkg::ssb_cond_s cond_in,
    input wire logic secure_set_in,
    input wire logic erase_in,
    // readout port
    input wire logic read_req_in,
    input wire logic [7:0] read_addr_in,
    output logic read_valid_out,
    output logic read_blocked_out,
    output ssb_pkg::ssb_word_s read_word_out,
    // state outputs
    output logic [7:0] outputs_out,
    output logic [7:0] state_addr_out,
    output logic [7:0] loop_count_out,
    output logic secure_out
);
    ssb_pkg::ssb_word_s mem [ssb_pkg::WORDS];
    logic [7:0] stack_mem [ssb_pkg::STACK_DEPTH];

    ssb_pkg::ssb_word_s pipe_reg;
    logic [7:0] addr_reg;
    logic [7:0] loop_count_reg;
    logic [ssb_pkg::SP_W-1:0] sp_reg;
    logic [2:0] low_cnt_reg;
    logic [1:0] hold_reg;
    logic secure_reg;
    logic read_valid_reg;
    logic read_blocked_reg;
    ssb_pkg::ssb_word_s read_word_reg;

    // decode of the word now in the pipeline
    wire ssb_pkg::ssb_op_e op = pipe_reg.op;
    wire [7:0] seq_addr = addr_reg + 8'h01;
    wire [7:0] q_field = pipe_reg.primary_target; // [RULE_12]
    wire [7:0] d_field = pipe_reg.data_field; // [RULE_02] [RULE_12]
    wire stack_empty = (sp_reg == '0);
    wire stack_full = (sp_reg == ssb_pkg::SP_W'(ssb_pkg::STACK_DEPTH));
    wire [ssb_pkg::SP_W-1:0] top_idx = sp_reg - 5'h01;
    wire [7:0] stack_top = stack_empty ? 8'h00 : stack_mem[top_idx[3:0]];
    wire count_zero = (loop_count_reg == 8'h00);
    wire [7:0] call_ret = pipe_reg.return_point_clause ? d_field : seq_addr;

    wire is_push = (op == ssb_pkg::SSB_CALL) || (op == ssb_pkg::SSB_SAVE_LOAD_COUNT)
        || (op == ssb_pkg::SSB_PUSH) || (op == ssb_pkg::SSB_PUSH_INPUTS)
        || (op == ssb_pkg::SSB_PUSH_MASKED);
    wire is_pop = (op == ssb_pkg::SSB_RETURN) || (op == ssb_pkg::SSB_POP_COUNT)
        || (op == ssb_pkg::SSB_POP_XOR_COUNT);

    logic [7:0] dest_addr;
    logic [7:0] push_val;
    logic [7:0] count_next;

    always_comb
    begin
        dest_addr = q_field;
        push_val = 8'h00;
        count_next = loop_count_reg; // [RULE_11]
        unique case (op)
            ssb_pkg::SSB_CONTINUE: dest_addr = seq_addr; // [RULE_03]
            ssb_pkg::SSB_JUMP: dest_addr = q_field; // [RULE_04]
            ssb_pkg::SSB_CALL:
            begin
                dest_addr = q_field; // [RULE_05]
                push_val = call_ret; // [RULE_05]
            end
            ssb_pkg::SSB_RETURN: dest_addr = stack_top; // [RULE_06]
            ssb_pkg::SSB_LOAD_COUNT: count_next = d_field;
            ssb_pkg::SSB_LOOP_COUNT:
            begin
                dest_addr = count_zero ? d_field : q_field;
                count_next = count_zero ? 8'h00 : loop_count_reg - 8'h01;
            end
            ssb_pkg::SSB_DEC_COUNT:
                count_next = count_zero ? 8'h00 : loop_count_reg - 8'h01;
            ssb_pkg::SSB_SAVE_LOAD_COUNT:
            begin
                push_val = loop_count_reg;
                count_next = d_field;
            end
            ssb_pkg::SSB_POP_COUNT: count_next = stack_top;
            ssb_pkg::SSB_PUSH: push_val = d_field;
            ssb_pkg::SSB_PUSH_INPUTS: push_val = data_in;
            ssb_pkg::SSB_PUSH_MASKED: push_val = data_in & d_field;
            ssb_pkg::SSB_POP_XOR_COUNT: count_next = stack_top ^ d_field;
            default: dest_addr = seq_addr;
        endcase
    end

    // multi-way branch: low two address bits come from the inputs
    logic [ssb_pkg::SEL_W-1:0] branch_sel;

    ssb_branch_select u_branch_select (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .cond_we_in(cond_we_in),
        .cond_idx_in(cond_idx_in),
        .cond_in(cond_in),
        .erase_in(erase_in),
        .data_in(data_in),
        .sel_out(branch_sel)
    );

    wire in_mwb = ((dest_addr & ssb_pkg::MWB_MASK) == ssb_pkg::MWB_BASE);
    wire [7:0] fetch_addr = in_mwb ? {dest_addr[7:2], branch_sel} : dest_addr; // [RULE_07]

    // restart pin is sampled only at the edge, so a low pulse between edges is missed
    wire restart_now = !restart_pin_low_in; // [RULE_10]
    wire long_release = (low_cnt_reg > ssb_pkg::RESET_LONG_EDGES);
    wire in_release = (low_cnt_reg != 3'h0);
    wire stall = (in_release && long_release) || (hold_reg > 2'h1); // [RULE_01]
    wire advance = !restart_now && !stall;
    wire do_push = advance && is_push && !stack_full;
    wire do_pop = advance && is_pop && !stack_empty;

    logic [1:0] hold_next;
    always_comb
    begin
        if (in_release)
            hold_next = long_release ? ssb_pkg::RELEASE_HOLD_EDGES : 2'h0; // [RULE_01]
        else if (hold_reg != 2'h0)
            hold_next = hold_reg - 2'h1;
        else
            hold_next = 2'h0;
    end

    // sequencing state
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pipe_reg <= ssb_pkg::WORD_RESET;
            addr_reg <= ssb_pkg::BOOT_ADDR;
            loop_count_reg <= ssb_pkg::COUNT_RESET;
            sp_reg <= '0;
            low_cnt_reg <= 3'h0;
            hold_reg <= 2'h0;
        end
        else if (restart_now)
        begin
            pipe_reg <= mem[ssb_pkg::BOOT_ADDR]; // [RULE_01]
            addr_reg <= ssb_pkg::BOOT_ADDR;
            sp_reg <= '0;
            low_cnt_reg <= (low_cnt_reg == 3'h7) ? 3'h7 : low_cnt_reg + 3'h1;
            hold_reg <= 2'h0;
        end
        else
        begin
            low_cnt_reg <= 3'h0;
            hold_reg <= hold_next;
            if (advance)
            begin
                pipe_reg <= mem[fetch_addr]; // [RULE_13]
                addr_reg <= fetch_addr;
                loop_count_reg <= count_next; // [RULE_11]
                if (do_push)
                    sp_reg <= sp_reg + 5'h01;
                else if (do_pop)
                    sp_reg <= sp_reg - 5'h01; // [RULE_06]
            end
        end
    end

    // stack storage
    always_ff @(posedge clk_in)
    begin
        if (do_push)
            stack_mem[sp_reg[3:0]] <= push_val; // [RULE_05]
    end

    // program store, security bit and erase
    always_ff @(posedge clk_in)
    begin
        if (erase_in)
        begin
            for (int k = 0; k < ssb_pkg::WORDS; k++)
                mem[k] <= ssb_pkg::WORD_RESET; // [RULE_08]
        end
        else if (prog_we_in)
            mem[prog_addr_in] <= prog_word_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in || erase_in)
            secure_reg <= 1'b0; // [RULE_08]
        else if (secure_set_in)
            secure_reg <= 1'b1;
    end

    // readout, refused while secured
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            read_valid_reg <= 1'b0;
            read_blocked_reg <= 1'b0;
            read_word_reg <= ssb_pkg::WORD_RESET;
        end
        else
        begin
            read_valid_reg <= read_req_in && !secure_reg;
            read_blocked_reg <= read_req_in && secure_reg; // [RULE_08]
            read_word_reg <= (read_req_in && !secure_reg) ? mem[read_addr_in]
                : ssb_pkg::WORD_RESET;
        end
    end

    assign read_valid_out = read_valid_reg;
    assign read_blocked_out = read_blocked_reg;
    assign read_word_out = read_word_reg;
    assign outputs_out = pipe_reg.outputs;
    assign state_addr_out = addr_reg;
    assign loop_count_out = loop_count_reg;
    assign secure_out = secure_reg;
endmodule
`default_nettype wire

// [bench/ssb_seq_chk.sv]
// assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module ssb_seq_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // watched inputs
    input wire logic restart_pin_low_in,
    input wire logic secure_set_in,
    input wire logic erase_in,
    input wire logic read_req_in,
    // watched outputs
    input wire logic read_valid_out,
    input wire logic read_blocked_out,
    input wire ssb_pkg::ssb_word_s read_word_out,
    input wire logic [7:0] state_addr_out,
    input wire logic [7:0] loop_count_out,
    input wire logic secure_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    restart_boot_a: assert property (!restart_pin_low_in |=> state_addr_out == 8'h00)
        else $error("restart missed boot word");
    restart_count_a: assert property (!restart_pin_low_in |=> $stable(loop_count_out))
        else $error("restart moved counter");
    long_hold_a: assert property (!restart_pin_low_in [*4] ##1 restart_pin_low_in
        |=> state_addr_out == 8'h00 ##1 state_addr_out == 8'h00)
        else $error("boot word not held");
    read_grant_a: assert property (read_req_in && !secure_out && !secure_set_in
        |=> read_valid_out && !read_blocked_out)
        else $error("open read not answered");
    read_block_a: assert property (read_req_in && secure_out && !erase_in
        |=> read_blocked_out && !read_valid_out && read_word_out == '0)
        else $error("secured read leaked");
    secure_set_a: assert property (secure_set_in && !erase_in |=> secure_out)
        else $error("security bit not set");
    secure_erase_a: assert property (erase_in |=> !secure_out)
        else $error("erase kept security bit");
    secure_keep_a: assert property (secure_out && !erase_in |=> secure_out)
        else $error("security bit lost");
endmodule
bind ssb_sequencer ssb_seq_chk u_ssb_seq_chk (.clk_in, .reset_in, .restart_pin_low_in,
    .secure_set_in, .erase_in, .read_req_in, .read_valid_out, .read_blocked_out,
    .read_word_out, .state_addr_out, .loop_count_out, .secure_out);
`default_nettype wire

// [bench/ssb_ext_inputs.sv]
// outside logic presenting general inputs aligned to the clock
`timescale 1ns/1ps
`default_nettype none
module ssb_ext_inputs (
    // clock and wanted value
    input wire logic clk_in,
    input wire logic [7:0] value_in,
    // general inputs
    output logic [7:0] data_out
);
    initial data_out = 8'h00;
    // change on the falling edge, clear of the sampling edge
    always @(negedge clk_in)
        data_out <= value_in;
endmodule
`default_nettype wire

// [bench/ssb_sequencer_test.sv]
// self-checking bench of the state sequencer
`timescale 1ns/1ps
`default_nettype none
module ssb_sequencer_test;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic restart_pin_low_in = 1'b0;
    logic prog_we_in = 1'b0;
    logic [7:0] prog_addr_in = 8'h00;
    ssb_pkg::ssb_word_s prog_word_in = '0;
    logic cond_we_in = 1'b0;
    logic [1:0] cond_idx_in = 2'h0;
    ssb_pkg::ssb_cond_s cond_in = '0;
    logic secure_set_in = 1'b0;
    logic erase_in = 1'b0;
    logic read_req_in = 1'b0;
    logic [7:0] read_addr_in = 8'h00;
    logic [7:0] value = 8'h00;
    logic [7:0] data_in;
    logic read_valid_out;
    logic read_blocked_out;
    ssb_pkg::ssb_word_s read_word_out;
    logic [7:0] outputs_out;
    logic [7:0] state_addr_out;
    logic [7:0] loop_count_out;
    logic secure_out;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] plist [11] = '{8'h00, 8'h01, 8'h10, 8'h20, 8'h30, 8'h40, 8'h11,
        8'hc4, 8'hc5, 8'hc6, 8'hc7};
    logic [7:0] wa [15] = '{8'h00, 8'h00, 8'h01, 8'h10, 8'h20, 8'h30, 8'h40, 8'h11,
        8'hc4, 8'h11, 8'hc5, 8'h11, 8'hc6, 8'h11, 8'hc7};
    logic [7:0] wd [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'haa, 8'haa,
        8'h05, 8'h05, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
    ssb_pkg::ssb_cond_s clist [3] = '{'{8'hff, 8'haa}, '{8'h0f, 8'h05}, '{8'h80, 8'h80}};
    logic [7:0] ca [12] = '{8'h50, 8'h51, 8'h51, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
        8'h56, 8'h57, 8'h58, 8'h59};
    logic [7:0] cc [12] = '{8'h5a, 8'h02, 8'h01, 8'h00, 8'h00, 8'h07, 8'h06, 8'h00,
        8'h00, 8'h08, 8'h08, 8'h08};
    logic [7:0] cd [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5b, 8'h00,
        8'h59, 8'h00, 8'h00, 8'h00};
    always #10 clk_in = ~clk_in;
    ssb_sequencer u_ssb_sequencer (.clk_in, .reset_in, .restart_pin_low_in, .data_in,
        .prog_we_in, .prog_addr_in, .prog_word_in, .cond_we_in, .cond_idx_in, .cond_in,
        .secure_set_in, .erase_in, .read_req_in, .read_addr_in, .read_valid_out,
        .read_blocked_out, .read_word_out, .outputs_out, .state_addr_out,
        .loop_count_out, .secure_out);
    ssb_ext_inputs u_ssb_ext_inputs (.clk_in, .value_in(value), .data_out(data_in));
    function automatic ssb_pkg::ssb_word_s word_of(input logic [7:0] a);
        logic [7:0] o;
        o = a ^ 8'h3c;
        case (a)
            8'h00: word_of = '{1'b0, ssb_pkg::SSB_CONTINUE, 8'h00, 8'h00, o};
            8'h01: word_of = '{1'b0, ssb_pkg::SSB_LOAD_COUNT, 8'h10, 8'h5a, o};
            8'h10: word_of = '{1'b0, ssb_pkg::SSB_CALL, 8'h20, 8'h00, o};
            8'h20: word_of = '{1'b1, ssb_pkg::SSB_CALL, 8'h30, 8'h40, o};
            8'h30, 8'h40, 8'h58: word_of = '{1'b0, ssb_pkg::SSB_RETURN, 8'h00, 8'h00, o};
            8'h50: word_of = '{1'b0, ssb_pkg::SSB_LOAD_COUNT, 8'h51, 8'h02, o};
            8'h51: word_of = '{1'b0, ssb_pkg::SSB_LOOP_COUNT, 8'h51, 8'h52, o};
            8'h52: word_of = '{1'b0, ssb_pkg::SSB_SAVE_LOAD_COUNT, 8'h53, 8'h07, o};
            8'h53: word_of = '{1'b0, ssb_pkg::SSB_DEC_COUNT, 8'h54, 8'h00, o};
            8'h54: word_of = '{1'b0, ssb_pkg::SSB_POP_COUNT, 8'h55, 8'h00, o};
            8'h55: word_of = '{1'b0, ssb_pkg::SSB_PUSH_MASKED, 8'h56, 8'h0f, o};
            8'h56: word_of = '{1'b0, ssb_pkg::SSB_POP_XOR_COUNT, 8'h57, 8'h03, o};
            8'h57: word_of = '{1'b0, ssb_pkg::SSB_PUSH_INPUTS, 8'h58, 8'h00, o};
            8'h11: word_of = '{1'b0, ssb_pkg::SSB_JUMP, 8'hc4, 8'h00, o};
            default: word_of = '{1'b0, ssb_pkg::SSB_JUMP, 8'h11, 8'h00, o};
        endcase
    endfunction
    task automatic check(input logic [28:0] seen, input logic [28:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // the value given reaches the inputs one cycle later, for the next word
    task automatic step(input logic [7:0] a, input logic [7:0] cnt, input logic [7:0] d);
        @(negedge clk_in);
        check(state_addr_out, a);
        check(outputs_out, a ^ 8'h3c);
        check(loop_count_out, cnt);
        value <= d;
    endtask
    task automatic sc_walk;
        erase_in = 1'b1;
        @(negedge clk_in);
        erase_in = 1'b0;
        prog_we_in = 1'b1;
        foreach (plist[i])
        begin
            prog_addr_in = plist[i];
            prog_word_in = word_of(plist[i]);
            @(negedge clk_in);
        end
        prog_we_in = 1'b0;
        cond_we_in = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            cond_idx_in = i[1:0];
            cond_in = clist[i];
            @(negedge clk_in);
        end
        cond_we_in = 1'b0;
        restart_pin_low_in = 1'b1;
        for (int i = 0; i < 15; i++)
            step(wa[i], (i < 3) ? 8'h00 : 8'h5a, wd[i]);
    endtask
    task automatic read_chk(input logic v, input ssb_pkg::ssb_word_s w);
        read_req_in = 1'b1;
        read_addr_in = 8'h20;
        @(negedge clk_in);
        check({read_valid_out, read_blocked_out}, {v, !v});
        check(read_word_out, w);
        read_req_in = 1'b0;
    endtask
    task automatic sc_secure;
        read_chk(1'b1, word_of(8'h20));
        secure_set_in = 1'b1;
        @(negedge clk_in);
        secure_set_in = 1'b0;
        check(secure_out, 1'b1);
        read_chk(1'b0, '0);
        erase_in = 1'b1;
        @(negedge clk_in);
        erase_in = 1'b0;
        check(secure_out, 1'b0);
        read_chk(1'b1, '0);
    endtask
    // counter and stack instructions, entered by a restart of one edge
    task automatic sc_count;
        prog_we_in = 1'b1;
        prog_addr_in = 8'h00;
        prog_word_in = '{1'b0, ssb_pkg::SSB_JUMP, 8'h50, 8'h00, 8'h3c};
        @(negedge clk_in);
        for (int i = 0; i < 10; i++)
        begin
            prog_addr_in = 8'h50 + 8'(i);
            prog_word_in = word_of(8'h50 + 8'(i));
            @(negedge clk_in);
        end
        prog_we_in = 1'b0;
        restart_pin_low_in = 1'b0;
        @(negedge clk_in);
        check(state_addr_out, 8'h00);
        check(outputs_out, 8'h3c);
        restart_pin_low_in = 1'b1;
        for (int i = 0; i < 12; i++)
            step(ca[i], cc[i], cd[i]);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            end_sim;
        end
    end
    initial
    begin
        repeat (16) @(negedge clk_in);
        reset_in = 1'b0;
        @(negedge clk_in);
        sc_walk;
        sc_secure;
        sc_count;
        end_sim;
    end
endmodule
`default_nettype wire
